// [test/orp_otp_model.sv]
module orp_otp_model
  import orp_pkg::*;
#(
  parameter int          PW_CYC     = 20,
  parameter logic [7:0]  MAKER_CODE = 8'h5a,
  parameter logic [7:0]  TYPE_CODE  = 8'hc3
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Device pins
  input  wire orp_pins_t  pins,
  output logic [7:0]      data_in,
  // Stubborn cell setup
  input  wire logic [1:0] slow_addr,
  input  wire logic [4:0] need,
  // Observation
  output int              n_pulses,
  output int              n_bad,
  output logic [3:0]      low_mask
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [4];
  int         hits [4];
  int         pw;
  logic [7:0] last;
  logic       rd_on;
  logic       id_on;
  logic       vpp_q;
  logic       viol;
  logic [1:0] a;
  orp_ctrl_t  c;

  assign c = pins.ctrl;
  assign a = pins.addr[1:0];
  assign rd_on = !c.ce_n && !c.oe_n && c.program_strobe_n;
  assign id_on = rd_on && c.id_hv_en && pins.addr[17:1] == 17'h00000;

  always_comb begin
    if (c.data_oe)
      data_in = pins.data_out;
    else if (id_on)
      data_in = pins.addr[0] ? TYPE_CODE : MAKER_CODE;
    else if (rd_on)
      data_in = mem[a];
    else
      data_in = ~last; // Floating bus must not look valid
  end

  always_comb begin
    viol = 1'b0;
    if (!c.program_strobe_n && (c.ce_n || !c.oe_n || !c.data_oe || !c.vcc_prog_en || !c.vpp_prog_en))
      viol = 1'b1;
    if (c.program_strobe_n && pw != 0 && pw != PW_CYC)
      viol = 1'b1;
    if (c.vpp_prog_en && !vpp_q && (pins.addr != 18'h00000 || !c.vcc_prog_en))
      viol = 1'b1;
    if (c.data_oe && rd_on)
      viol = 1'b1;
    // output enable never ahead of chip enable
    if (!c.oe_n && c.ce_n)
      viol = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mem <= '{default: 8'hff};
      hits <= '{default: 0};
      pw <= 0;
      last <= 8'h00;
      vpp_q <= 1'b0;
      n_pulses <= 0;
      n_bad <= 0;
      low_mask <= 4'h0;
    end else begin
      last <= data_in;
      vpp_q <= c.vpp_prog_en;
      if (viol)
        n_bad <= n_bad + 1;
      if (!c.program_strobe_n)
        pw <= pw + 1;
      if (c.program_strobe_n && pw != 0) begin
        pw <= 0;
        n_pulses <= n_pulses + 1;
        hits[a] <= hits[a] + 1;
        // Cells only clear; a stubborn one needs several pulses
        if (a != slow_addr || hits[a] + 1 >= int'(need))
          mem[a] <= mem[a] & pins.data_out;
      end
      if (rd_on && !c.vcc_prog_en && !c.vpp_prog_en && !c.id_hv_en)
        low_mask[a] <= 1'b1;
    end
  end
endmodule : orp_otp_model

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import orp_pkg::*;

  localparam int         PW    = 20;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] DTYPE = 8'hc3; // Arbitrary value

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        start_prog = 1'b0;
  logic        start_id = 1'b0;
  logic        id_byte_select = 1'b0;
  logic [17:0] src_addr;
  logic [7:0]  src_data;
  logic [7:0]  data_in;
  logic [7:0]  id_code;
  orp_pins_t   pins;
  orp_status_t status;
  logic [4:0]  need = 5'h01;
  logic [3:0]  low_mask;
  int          n_pulses;
  int          n_bad;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [7:0]  img [4] = '{8'h3c, 8'h00, 8'ha5, 8'h7e};

  assign src_data = img[src_addr[1:0]];
  always #2 sys_clk = ~sys_clk;

  orp_programmer #(.PW_CYC(PW), .LAST_ADDR(18'h00003)) orp_programmer_i (
    .sys_clk(sys_clk), .rst(rst), .start_prog(start_prog), .start_id(start_id),
    .id_byte_select(id_byte_select), .src_addr(src_addr), .src_data(src_data),
    .pins(pins), .data_in(data_in), .status(status), .id_code(id_code));

  orp_otp_model #(.PW_CYC(PW), .MAKER_CODE(MAKER), .TYPE_CODE(DTYPE)) orp_otp_model_i (
    .sys_clk(sys_clk), .rst(rst), .pins(pins), .data_in(data_in), .slow_addr(2'h2),
    .need(need), .n_pulses(n_pulses), .n_bad(n_bad), .low_mask(low_mask));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
  endtask : do_reset

  task automatic pulse_cmd(input logic prog);
    @(negedge sys_clk);
    start_prog = prog;
    start_id = !prog;
    @(negedge sys_clk);
    start_prog = 1'b0;
    start_id = 1'b0;
    for (int i = 0; i < 40000 && status.done !== 1'b1; i++)
      @(negedge sys_clk);
    check("done", {31'h0, status.done}, 32'h1);
  endtask : pulse_cmd

  task automatic t_reset();
    do_reset();
    check("ctrl", {25'h0, pins.ctrl}, {25'h0, 7'b1110000});
    check("status", {27'h0, status}, 32'h0);
  endtask : t_reset

  task automatic t_id(input logic sel, input logic [7:0] exp);
    @(negedge sys_clk);
    id_byte_select = sel;
    pulse_cmd(1'b0);
    check("id_code", {24'h0, id_code}, {24'h0, exp});
    check("id_valid", {31'h0, status.id_valid}, 32'h1);
    check("id pass fail", {30'h0, status.pass, status.fail}, 32'h0);
    check("id pin faults", n_bad, 32'h0);
  endtask : t_id

  task automatic t_prog(input logic [4:0] nd, input logic ok, input int pulses);
    do_reset();
    need = nd;
    pulse_cmd(1'b1);
    check("pass", {31'h0, status.pass}, {31'h0, ok});
    check("fail", {31'h0, status.fail}, {31'h0, !ok});
    check("pulses", n_pulses, pulses);
    check("pin faults", n_bad, 32'h0);
    check("supplies", {30'h0, pins.ctrl.vcc_prog_en, pins.ctrl.vpp_prog_en}, 32'h0);
    if (ok) begin
      check("low reads", {28'h0, low_mask}, 32'hf);
      for (int k = 0; k < 4; k++)
        check("cell", {24'h0, orp_otp_model_i.mem[k]}, {24'h0, img[k]});
    end
  endtask : t_prog

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    #300000;
    n_fail++;
    give_verdict();
  end

  initial begin
    t_reset();
    t_id(1'b0, MAKER);
    t_id(1'b1, DTYPE);
    t_prog(5'h01, 1'b1, 4);
    t_prog(5'h0b, 1'b1, 14);
    t_prog(5'h0c, 1'b0, 14);
    give_verdict();
  end
endmodule : tb

// [verilog/orp_defines.svh]
`ifndef ORP_DEFINES_SVH
`define ORP_DEFINES_SVH

// Pin and state encoding widths
`define ORP_ADDR_W      18
`define ORP_DATA_W      8
`define ORP_ST_W        11

// Clock and documented times in ns
`define ORP_CLK_NS      4
`define ORP_PW_NOM_NS   100000
`define ORP_PW_MIN_NS   95000
`define ORP_PW_MAX_NS   105000
`define ORP_SETUP_NS    2000
`define ORP_OE_DATA_NS  150
`define ORP_FLOAT_NS    130

// Pulse budget per byte in the verify pass
`define ORP_MAX_PULSES  10
`define ORP_RETRY_W     4

`endif

// [verilog/orp_pkg.sv]
`include "orp_defines.svh"

package orp_pkg;

  typedef enum logic [`ORP_ST_W-1:0] {
    ORP_IDLE     = 11'h001,
    ORP_SUP_UP   = 11'h002,
    ORP_PG_SET   = 11'h004,
    ORP_PG_PULSE = 11'h008,
    ORP_PG_HOLD  = 11'h010,
    ORP_V_READ   = 11'h020,
    ORP_V_FLOAT  = 11'h040,
    ORP_SUP_DN   = 11'h080,
    ORP_F_READ   = 11'h100,
    ORP_ID_SET   = 11'h200,
    ORP_ID_READ  = 11'h400
  } orp_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic program_strobe_n;
    logic data_oe;
    logic vcc_prog_en;
    logic vpp_prog_en;
    logic id_hv_en;
  } orp_ctrl_t;

  typedef struct packed {
    logic [`ORP_ADDR_W-1:0] addr;
    logic [`ORP_DATA_W-1:0] data_out;
    orp_ctrl_t              ctrl;
  } orp_pins_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic pass;
    logic fail;
    logic id_valid;
  } orp_status_t;

endpackage : orp_pkg

// [verilog/orp_programmer.sv]
`include "orp_defines.svh"

module orp_programmer
  import orp_pkg::*;
#(
  parameter int                     PW_CYC    = `ORP_PW_NOM_NS / `ORP_CLK_NS,
  parameter logic [`ORP_ADDR_W-1:0] LAST_ADDR = {`ORP_ADDR_W{1'b1}}
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Commands
  input  wire logic                   start_prog,
  input  wire logic                   start_id,
  input  wire logic                   id_byte_select,
  // Source image
  output logic [`ORP_ADDR_W-1:0]      src_addr,
  input  wire logic [`ORP_DATA_W-1:0] src_data,
  // Device pins
  output orp_pins_t                   pins,
  input  wire logic [`ORP_DATA_W-1:0] data_in,
  // Status
  output orp_status_t                 status,
  output logic [`ORP_DATA_W-1:0]      id_code
);

  // Least times round up; one extra cycle covers the source data register lag
  localparam int SETUP_CYC = (`ORP_SETUP_NS + `ORP_CLK_NS - 1) / `ORP_CLK_NS + 1;
  localparam int OE_CYC    = (`ORP_OE_DATA_NS + `ORP_CLK_NS - 1) / `ORP_CLK_NS;
  localparam int FLOAT_CYC = (`ORP_FLOAT_NS + `ORP_CLK_NS - 1) / `ORP_CLK_NS;
  localparam int PW_TOL    = PW_CYC * (`ORP_PW_MAX_NS - `ORP_PW_NOM_NS) / `ORP_PW_NOM_NS;
  localparam int PW_LO     = PW_CYC - PW_TOL;
  localparam int PW_HI     = PW_CYC + PW_TOL;
  localparam int CNT_W     = $clog2(PW_CYC + SETUP_CYC + 1);

  orp_state_t                 state_reg;
  orp_state_t                 state_next;
  orp_ctrl_t                  ctrl_reg;
  logic [`ORP_ADDR_W-1:0]     addr_reg;
  logic [`ORP_DATA_W-1:0]     data_reg;
  logic [`ORP_RETRY_W-1:0]    retry_reg;
  logic                       phase_reg;
  orp_status_t                status_reg;
  logic [`ORP_DATA_W-1:0]     id_code_reg;
  logic                       tmr_exp;
  logic                       tmr_start;
  logic                       last;
  logic                       match;
  logic                       idle_go;
  logic [31:0]                pw_cnt;

  function automatic orp_ctrl_t ctrl_of(orp_state_t s);
    orp_ctrl_t c;
    c = '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1, data_oe: 1'b0,
          vcc_prog_en: 1'b0, vpp_prog_en: 1'b0, id_hv_en: 1'b0};
    unique case (s)
      ORP_IDLE, ORP_SUP_DN: begin
      end
      ORP_SUP_UP: begin
        c.vcc_prog_en = 1'b1;
        c.vpp_prog_en = 1'b1;
      end
      ORP_PG_SET, ORP_PG_HOLD, ORP_PG_PULSE: begin
        c.vcc_prog_en      = 1'b1;
        c.vpp_prog_en      = 1'b1;
        c.ce_n             = 1'b0;
        c.data_oe          = 1'b1;
        c.program_strobe_n = (s != ORP_PG_PULSE);
      end
      // output enable falls while chip enable is already low from the hold state
      ORP_V_READ: begin
        c.vcc_prog_en = 1'b1;
        c.vpp_prog_en = 1'b1;
        c.ce_n        = 1'b0;
        c.oe_n        = 1'b0;
      end
      // Bus left floating before the host drives data again
      ORP_V_FLOAT: begin
        c.vcc_prog_en = 1'b1;
        c.vpp_prog_en = 1'b1;
        c.ce_n        = 1'b0;
      end
      ORP_F_READ: begin
        c.ce_n = 1'b0;
        c.oe_n = 1'b0;
      end
      // high voltage on the identification line
      ORP_ID_SET, ORP_ID_READ: begin
        c.id_hv_en = 1'b1;
        c.ce_n     = (s == ORP_ID_SET);
        c.oe_n     = (s == ORP_ID_SET);
      end
    endcase
    return c;
  endfunction : ctrl_of

  function automatic logic [CNT_W-1:0] wait_of(orp_state_t s);
    unique case (s)
      ORP_PG_PULSE:                         return CNT_W'(PW_CYC);
      ORP_V_READ, ORP_F_READ, ORP_ID_READ:  return CNT_W'(OE_CYC);
      ORP_V_FLOAT:                          return CNT_W'(FLOAT_CYC);
      ORP_IDLE:                             return CNT_W'(1);
      default:                              return CNT_W'(SETUP_CYC);
    endcase
  endfunction : wait_of

  assign last      = (addr_reg == LAST_ADDR);
  assign match     = (data_in == src_data);
  assign idle_go   = (state_reg == ORP_IDLE) && (start_prog || start_id);
  assign tmr_start = (state_next != state_reg) || tmr_exp;

  orp_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (tmr_start),
    .load    (wait_of(state_next)),
    .expired (tmr_exp)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ORP_IDLE: begin
        if (start_prog) begin
          state_next = ORP_SUP_UP;
        end else if (start_id) begin
          state_next = ORP_ID_SET;
        end
      end
      ORP_SUP_UP:   if (tmr_exp) state_next = ORP_PG_SET;
      ORP_PG_SET:   if (tmr_exp) state_next = ORP_PG_PULSE;
      ORP_PG_PULSE: if (tmr_exp) state_next = ORP_PG_HOLD;
      // next address without verify in the first pass
      ORP_PG_HOLD: begin
        if (tmr_exp) begin
          state_next = (phase_reg || last) ? ORP_V_READ : ORP_PG_SET;
        end
      end
      // out of pulses stops the run
      ORP_V_READ: begin
        if (tmr_exp) begin
          if (match) begin
            state_next = last ? ORP_SUP_DN : ORP_V_READ;
          end else begin
            state_next = (retry_reg == `ORP_RETRY_W'(`ORP_MAX_PULSES)) ? ORP_IDLE : ORP_V_FLOAT;
          end
        end
      end
      ORP_V_FLOAT:  if (tmr_exp) state_next = ORP_PG_SET;
      ORP_SUP_DN:   if (tmr_exp) state_next = ORP_F_READ;
      ORP_F_READ: begin
        if (tmr_exp && (!match || last)) begin
          state_next = ORP_IDLE;
        end
      end
      ORP_ID_SET:   if (tmr_exp) state_next = ORP_ID_READ;
      ORP_ID_READ:  if (tmr_exp) state_next = ORP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ORP_IDLE;
      ctrl_reg  <= '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1, default: 1'b0};
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_of(state_next);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
    end else if (idle_go) begin
      addr_reg <= start_prog ? '0 : {{(`ORP_ADDR_W-1){1'b0}}, id_byte_select};
    end else if (tmr_exp) begin
      if ((state_reg == ORP_PG_HOLD) && !phase_reg) begin
        addr_reg <= last ? '0 : addr_reg + 1'b1;
      end else if ((state_reg == ORP_V_READ) && match) begin
        addr_reg <= last ? '0 : addr_reg + 1'b1;
      end else if ((state_reg == ORP_F_READ) && match && !last) begin
        addr_reg <= addr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_reg <= '0;
    end else begin
      data_reg <= src_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      retry_reg <= '0;
      phase_reg <= 1'b0;
    end else if (idle_go) begin
      retry_reg <= '0;
      phase_reg <= 1'b0;
    end else if (tmr_exp && (state_reg == ORP_PG_HOLD)) begin
      if (phase_reg) begin
        retry_reg <= retry_reg + 1'b1;
      end else if (last) begin
        phase_reg <= 1'b1;
      end
    end else if (tmr_exp && (state_reg == ORP_V_READ) && match) begin
      retry_reg <= '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
    end else begin
      status_reg.busy <= (state_next != ORP_IDLE);
      status_reg.done <= (state_reg != ORP_IDLE) && (state_next == ORP_IDLE);
      if (idle_go) begin
        status_reg.pass     <= 1'b0;
        status_reg.fail     <= 1'b0;
        status_reg.id_valid <= 1'b0;
      end else if (tmr_exp && !match && (state_reg == ORP_V_READ) && (state_next == ORP_IDLE)) begin
        status_reg.fail <= 1'b1;
      end else if (tmr_exp && (state_reg == ORP_F_READ)) begin
        status_reg.fail <= !match;
        status_reg.pass <= match && last;
      end else if (tmr_exp && (state_reg == ORP_ID_READ)) begin
        status_reg.id_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      id_code_reg <= '0;
    end else if (tmr_exp && (state_reg == ORP_ID_READ)) begin
      id_code_reg <= data_in;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pw_cnt <= '0;
    end else if (!ctrl_reg.program_strobe_n) begin
      pw_cnt <= pw_cnt + 32'h1;
    end else begin
      pw_cnt <= '0;
    end
  end

  assign src_addr = addr_reg;
  assign pins     = '{addr: addr_reg, data_out: data_reg, ctrl: ctrl_reg};
  assign status   = status_reg;
  assign id_code  = id_code_reg;

  a_pulse_width: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(ctrl_reg.program_strobe_n) |-> (pw_cnt >= PW_LO) && (pw_cnt <= PW_HI))
    else $error("program pulse width out of window");

  a_supply_first: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(ctrl_reg.vpp_prog_en) |-> (addr_reg == '0) && ctrl_reg.vcc_prog_en && ctrl_reg.ce_n)
    else $error("supplies raised away from first address");

  a_first_pass: assert property (@(posedge sys_clk) disable iff (rst)
    !phase_reg && !ctrl_reg.program_strobe_n |=> ctrl_reg.oe_n [*8])
    else $error("verify read inside first pass");

  a_retry_bound: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ORP_PG_HOLD) && phase_reg && tmr_exp |=> (state_reg == ORP_V_READ) && !ctrl_reg.oe_n
      && (retry_reg <= `ORP_RETRY_W'(`ORP_MAX_PULSES)))
    else $error("retry pulse not followed by verify");

  a_fail_stop: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(status_reg.fail) && (retry_reg == `ORP_RETRY_W'(`ORP_MAX_PULSES)) |->
      (state_reg == ORP_IDLE) && !ctrl_reg.vpp_prog_en && status_reg.done)
    else $error("failed byte did not stop the run");

  a_next_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ORP_V_READ) && tmr_exp && match && !last |=> addr_reg == $past(addr_reg) + 1'b1)
    else $error("verified byte did not advance address");

  a_final_read: assert property (@(posedge sys_clk) disable iff (rst)
    (state_reg == ORP_F_READ) |-> !ctrl_reg.vcc_prog_en && !ctrl_reg.vpp_prog_en && phase_reg)
    else $error("final read at programming supplies");

  a_id_lines: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_reg.id_hv_en |-> (addr_reg[`ORP_ADDR_W-1:1] == '0) && !ctrl_reg.vpp_prog_en)
    else $error("identification address lines not low");

  a_pin_modes: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_reg.program_strobe_n |-> !ctrl_reg.ce_n && ctrl_reg.oe_n && ctrl_reg.data_oe)
    else $error("program strobe outside program cycle");

  a_read_mode: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_reg.oe_n |-> !ctrl_reg.ce_n && ctrl_reg.program_strobe_n && !ctrl_reg.data_oe)
    else $error("read with host driving data");

endmodule : orp_programmer

// [verilog/orp_timer.sv]
module orp_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Load
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  // Expiry
  output logic                  expired
);

  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= load;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // A load of N keeps the caller in its state for exactly N cycles
  // Pure function of the count: gating with start would close a loop through the caller
  assign expired = (count_reg == CNT_W'(1));

endmodule : orp_timer
